// file: rtl/csi_pkg.sv
`default_nettype none
// shared constants for the can status and interrupt register block
package csi_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] ADDR_GEN_STATUS    = 4'h0;
  localparam logic [3:0] ADDR_GEN_IRQ_FLAGS = 4'h1;
  localparam logic [3:0] ADDR_GEN_IRQ_EN    = 4'h2;
  localparam logic [3:0] ADDR_OBJ_EN_LO     = 4'h3;
  localparam logic [3:0] ADDR_OBJ_EN_HI     = 4'h4;
  localparam logic [3:0] ADDR_OBJ_IE_LO     = 4'h5;
  localparam logic [3:0] ADDR_OBJ_IE_HI     = 4'h6;
  localparam logic [3:0] ADDR_OBJ_SIT_LO    = 4'h7;
  localparam logic [3:0] ADDR_OBJ_SIT_HI    = 4'h8;
  localparam logic [3:0] ADDR_PRESCALER     = 4'h9;
  // general status bit positions
  localparam int STA_TX_ACTIVE  = 4;
  localparam int STA_RX_ACTIVE  = 3;
  localparam int STA_ON_STATE   = 2;
  localparam int STA_BUSOFF     = 1;
  localparam int STA_ERR_PASS   = 0;
  // general interrupt flag positions
  localparam int FLG_ANY        = 7;
  localparam int FLG_BUSOFF     = 6;
  localparam int FLG_TIMER_WRAP = 5;
  localparam int FLG_BUFFER     = 4;
  localparam int FLG_STUFF      = 3;
  localparam int FLG_CRC        = 2;
  localparam int FLG_FORM       = 1;
  localparam int FLG_ACK        = 0;
  // general interrupt enable positions
  localparam int EN_GLOBAL      = 7;
  localparam int EN_BUSOFF      = 6;
  localparam int EN_RX          = 5;
  localparam int EN_TX          = 4;
  localparam int EN_OBJ_ERR     = 3;
  localparam int EN_BUFFER      = 2;
  localparam int EN_GEN_ERR     = 1;
  localparam int EN_TIMER_WRAP  = 0;
  // prescaler field
  localparam int PRE_LSB        = 1;
  localparam int PRE_MSB        = 6;
  // object count and reset values
  localparam int NUM_OBJ        = 15;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [14:0] RST_OBJ  = 15'h0000;
  localparam logic [5:0]  RST_PRE  = 6'h00;
endpackage
`default_nettype wire

// file: rtl/csi_quantum_gen.sv
`default_nettype none
// time quantum tick: one pulse every (divider + 1) clocks
module csi_quantum_gen
  import csi_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic [5:0] quantum_divider,
  output logic            quantum_tick
);
  logic [5:0] cnt_ff;   // cycles within one quantum
  logic [5:0] nxt_cnt;
  logic       tick_ff;  // registered tick
  logic       nxt_tick;

  // count up to the divider, then wrap and tick
  always_comb begin
    nxt_tick = 1'b0;
    nxt_cnt  = cnt_ff + 6'h01;
    if (cnt_ff >= quantum_divider) begin
      nxt_cnt  = 6'h00;
      nxt_tick = 1'b1;
    end
  end

  // register the count
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff  <= 6'h00;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign quantum_tick = tick_ff;
endmodule
`default_nettype wire

// file: rtl/csi_regs.sv
// What this block does
// (R1) tx_active reads one during frame, ack, ifs
// (R2) rx_active reads one while frame received
// (R3) controller_on_state follows real state, lags command
// (R4) busoff_state shows bus-off; entry only flags
// (R5) err_passive_state shows error-passive, no interrupt
// (R6) any_irq_flag ORs all sources except timer
// (R7) busoff flag set entering bus-off from passive
// (R8) timer wrap flag sets; write-one/handler clears
// (R9) buffer flag clear needs all configs rewritten
// (R10) stuff error flag on six equal bits
// (R11) crc error flag on checksum mismatch
// (R12) form error flag on fixed-format violation
// (R13) ack error flag when no dominant ack
// (R14) writing one clears each writable flag
// (R15) writing zero leaves flags unchanged
// (R16) global enable gates all but timer wrap
// (R17) separate enables gate each source, reset zero
// (R18) object in-use bit sets when configured enabled
// (R19) in-use clears on done, disable, abort, standby
// (R20) fifteen writable per-object interrupt enables
// (R21) per-object pending status, top bit reserved
// (R22) quantum equals divider plus one clocks
// (R23) software writes zero to prescaler reserved bits
// (R24) object-level errors never set general flags
// (R25) request lines: flag and enable both one
`default_nettype none
module csi_regs
  import csi_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // protocol engine state levels
  input  wire logic        eng_tx_active,
  input  wire logic        eng_rx_active,
  input  wire logic        eng_on_state,
  input  wire logic        eng_busoff,
  input  wire logic        eng_err_passive,
  // protocol engine event pulses
  input  wire logic        ev_timer_wrap,
  input  wire logic        ev_timer_handler,
  input  wire logic        ev_buffer_done,
  input  wire logic        ev_stuff_err,
  input  wire logic        ev_crc_err,
  input  wire logic        ev_form_err,
  input  wire logic        ev_ack_err,
  input  wire logic        ev_obj_matched,
  input  wire logic        buffer_cfg_rewritten,
  // message object events
  input  wire logic [14:0] obj_cfg_enable,
  input  wire logic [14:0] obj_cfg_disable,
  input  wire logic [14:0] obj_done,
  input  wire logic        abort_req,
  input  wire logic        standby_req,
  input  wire logic [14:0] obj_rx_pend,
  input  wire logic [14:0] obj_tx_pend,
  input  wire logic [14:0] obj_err_pend,
  // outputs to the engine and cpu
  output logic             quantum_tick,
  output logic [5:0]       quantum_divider,
  output logic             can_irq,
  output logic             timer_irq
);

  // decode helper used by the write paths
  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    hit = (a == o);
  endfunction

  // status register captured from engine levels
  logic [4:0]  status_ff;
  logic [4:0]  nxt_status;
  logic        busoff_d_ff;     // previous bus-off level
  logic        nxt_busoff_d;
  logic        passive_d_ff;    // error-passive before bus-off
  logic        nxt_passive_d;
  // writable general flags, bits 6..0
  logic [6:0]  flags_ff;
  logic [6:0]  nxt_flags;
  logic [7:0]  gie_ff;          // general enables
  logic [7:0]  nxt_gie;
  logic [14:0] obj_en_ff;       // objects in use
  logic [14:0] nxt_obj_en;
  logic [14:0] obj_ie_ff;       // per-object interrupt enables
  logic [14:0] nxt_obj_ie;
  logic [14:0] sit_ff;          // per-object pending
  logic [14:0] nxt_sit;
  logic [5:0]  pre_ff;          // quantum divider
  logic [5:0]  nxt_pre;
  logic [7:0]  rdata_ff;        // read data, one cycle late
  logic [7:0]  nxt_rdata;
  logic        can_irq_ff;
  logic        nxt_can_irq;
  logic        timer_irq_ff;
  logic        nxt_timer_irq;
  logic        any_flag;        // combined general flag
  logic        wr_flags;
  logic [6:0]  clr_mask;

  // status levels and bus-off edge history
  always_comb begin
    // (R1) transmit busy
    nxt_status[STA_TX_ACTIVE] = eng_tx_active;
    // (R2) receive busy
    nxt_status[STA_RX_ACTIVE] = eng_rx_active;
    // (R3) real operating state
    nxt_status[STA_ON_STATE]  = eng_on_state;
    // (R4) bus-off level
    nxt_status[STA_BUSOFF]    = eng_busoff;
    // (R5) error-passive level
    nxt_status[STA_ERR_PASS]  = eng_err_passive;
    // history for the bus-off entry edge
    nxt_busoff_d  = eng_busoff;
    nxt_passive_d = eng_err_passive;
  end

  // per-object pending, gated by class and object enables
  always_comb begin
    // each source class is gated before the object enable
    // (R21) pending needs a source and its enable
    nxt_sit = (obj_rx_pend & {NUM_OBJ{gie_ff[EN_RX]}})
            | (obj_tx_pend & {NUM_OBJ{gie_ff[EN_TX]}})
            | (obj_err_pend & {NUM_OBJ{gie_ff[EN_OBJ_ERR]}});
    nxt_sit = nxt_sit & obj_ie_ff;
  end

  // general interrupt flags
  always_comb begin
    // a write to the flag register acknowledges flags
    wr_flags = reg_wr && hit(reg_addr, ADDR_GEN_IRQ_FLAGS);
    // (R14) write one clears; (R15) zero keeps
    clr_mask = wr_flags ? reg_wdata[6:0] : 7'h00;
    // (R9) buffer flag clear blocked until configs rewritten
    if (!buffer_cfg_rewritten) begin
      clr_mask[FLG_BUFFER] = 1'b0;
    end
    // (R8) handler entry also clears
    if (ev_timer_handler) begin
      clr_mask[FLG_TIMER_WRAP] = 1'b1;
    end
    // apply clears first; the sets below override them
    nxt_flags = flags_ff & ~clr_mask;
    // set wins over clear
    // (R4) (R7) entry into bus-off from passive only
    if (eng_busoff && !busoff_d_ff && passive_d_ff) begin
      nxt_flags[FLG_BUSOFF] = 1'b1;
    end
    // (R8) timer wrap
    if (ev_timer_wrap) begin
      nxt_flags[FLG_TIMER_WRAP] = 1'b1;
    end
    if (ev_buffer_done) begin
      nxt_flags[FLG_BUFFER] = 1'b1;
    end
    // (R24) matched object errors stay at object level
    if (!ev_obj_matched) begin
      // (R10) stuff error
      if (ev_stuff_err) begin
        nxt_flags[FLG_STUFF] = 1'b1;
      end
      // (R11) crc error
      if (ev_crc_err) begin
        nxt_flags[FLG_CRC] = 1'b1;
      end
      // (R12) form error
      if (ev_form_err) begin
        nxt_flags[FLG_FORM] = 1'b1;
      end
      // (R13) ack error
      if (ev_ack_err) begin
        nxt_flags[FLG_ACK] = 1'b1;
      end
    end
  end

  // combined flag and request lines
  always_comb begin
    // (R6) (R17) every source but timer wrap, each gated
    any_flag = (flags_ff[FLG_BUSOFF] & gie_ff[EN_BUSOFF])
             | (flags_ff[FLG_BUFFER] & gie_ff[EN_BUFFER])
             | (|flags_ff[FLG_STUFF:FLG_ACK] & gie_ff[EN_GEN_ERR])
             | (|sit_ff);
    // (R16) (R25) global enable gates the controller line
    nxt_can_irq   = any_flag & gie_ff[EN_GLOBAL];
    // timer wrap stays out of the combined flag on purpose
    // (R16) (R25) timer line has its own enable only
    nxt_timer_irq = flags_ff[FLG_TIMER_WRAP] & gie_ff[EN_TIMER_WRAP];
  end

  // writable enables and prescaler
  always_comb begin
    // hold unless written
    nxt_gie    = gie_ff;
    nxt_obj_ie = obj_ie_ff;
    nxt_pre    = pre_ff;
    // (R17) general enables
    if (reg_wr && hit(reg_addr, ADDR_GEN_IRQ_EN)) begin
      nxt_gie = reg_wdata;
    end
    // (R20) per-object enables, low byte and high seven
    if (reg_wr && hit(reg_addr, ADDR_OBJ_IE_LO)) begin
      nxt_obj_ie[7:0] = reg_wdata;
    end
    // the reserved top bit of the high byte is dropped
    if (reg_wr && hit(reg_addr, ADDR_OBJ_IE_HI)) begin
      nxt_obj_ie[14:8] = reg_wdata[6:0];
    end
    // (R22) (R23) only bits 6:1 kept; reserved ignored
    if (reg_wr && hit(reg_addr, ADDR_PRESCALER)) begin
      nxt_pre = reg_wdata[PRE_MSB:PRE_LSB];
    end
  end

  // objects in use
  always_comb begin
    // (R18) set on enable config
    nxt_obj_en = obj_en_ff | obj_cfg_enable;
    // a freeing event in the same cycle beats a new enable
    // (R19) free on done, disable, abort or standby
    nxt_obj_en = nxt_obj_en & ~(obj_done | obj_cfg_disable);
    // abort or standby frees every object at once
    if (abort_req || standby_req) begin
      nxt_obj_en = RST_OBJ;
    end
  end

  // read data mux, answer in the next cycle
  always_comb begin
    nxt_rdata = RST_BYTE;
    // data only in the cycle after a read strobe, zero otherwise
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_GEN_STATUS:    nxt_rdata = {3'h0, status_ff};
        // (R6) read-only combined flag in bit 7
        ADDR_GEN_IRQ_FLAGS: nxt_rdata = {any_flag, flags_ff};
        ADDR_GEN_IRQ_EN:    nxt_rdata = gie_ff;
        ADDR_OBJ_EN_LO:     nxt_rdata = obj_en_ff[7:0];
        ADDR_OBJ_EN_HI:     nxt_rdata = {1'b0, obj_en_ff[14:8]};
        ADDR_OBJ_IE_LO:     nxt_rdata = obj_ie_ff[7:0];
        ADDR_OBJ_IE_HI:     nxt_rdata = {1'b0, obj_ie_ff[14:8]};
        ADDR_OBJ_SIT_LO:    nxt_rdata = sit_ff[7:0];
        // (R21) reserved top bit reads zero
        ADDR_OBJ_SIT_HI:    nxt_rdata = {1'b0, sit_ff[14:8]};
        ADDR_PRESCALER:     nxt_rdata = {1'b0, pre_ff, 1'b0};
        // unmapped address reads zero
        default:            nxt_rdata = RST_BYTE;
      endcase
    end
  end

  // status levels and their history
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      status_ff     <= 5'h00;
      busoff_d_ff   <= 1'b0;
      passive_d_ff  <= 1'b0;
    end else begin
      status_ff     <= nxt_status;
      busoff_d_ff   <= nxt_busoff_d;
      passive_d_ff  <= nxt_passive_d;
    end
  end

  // per-object pending
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sit_ff        <= RST_OBJ;
    end else begin
      sit_ff        <= nxt_sit;
    end
  end

  // general flags
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_ff      <= 7'h00;
    end else begin
      flags_ff      <= nxt_flags;
    end
  end

  // request lines
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      can_irq_ff    <= 1'b0;
      timer_irq_ff  <= 1'b0;
    end else begin
      can_irq_ff    <= nxt_can_irq;
      timer_irq_ff  <= nxt_timer_irq;
    end
  end

  // writable enables and prescaler
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      gie_ff        <= RST_BYTE;
      obj_ie_ff     <= RST_OBJ;
      pre_ff        <= RST_PRE;
    end else begin
      gie_ff        <= nxt_gie;
      obj_ie_ff     <= nxt_obj_ie;
      pre_ff        <= nxt_pre;
    end
  end

  // objects in use
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      obj_en_ff     <= RST_OBJ;
    end else begin
      obj_en_ff     <= nxt_obj_en;
    end
  end

  // read data
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff      <= RST_BYTE;
    end else begin
      rdata_ff      <= nxt_rdata;
    end
  end

  // the engine paces its bit timing from this tick
  // (R22) quantum tick generator
  csi_quantum_gen u_quantum (
    .mclk            (mclk),
    .sys_rst         (sys_rst),
    .quantum_divider (pre_ff),
    .quantum_tick    (quantum_tick)
  );

  assign reg_rdata       = rdata_ff;
  assign quantum_divider = pre_ff;
  assign can_irq         = can_irq_ff;
  assign timer_irq       = timer_irq_ff;
endmodule
`default_nettype wire

// file: dv/csi_regs_monitor.sv
`default_nettype none
// port-level checks on the status and interrupt register block
module csi_regs_monitor
  import csi_pkg::*;
(
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       eng_tx_active,
  input wire logic       eng_rx_active,
  input wire logic       eng_on_state,
  input wire logic       eng_busoff,
  input wire logic       eng_err_passive,
  input wire logic       ev_timer_wrap,
  input wire logic       quantum_tick,
  input wire logic [5:0] quantum_divider,
  input wire logic       can_irq,
  input wire logic       timer_irq
);
  logic [7:0] gie_ff;  // mirror of the enable register
  logic [7:0] cnt_ff;  // clocks since the last tick
  logic       chg_ff;  // divider moved in this period
  logic [5:0] div_ff;  // divider seen at the last edge
  wire  [4:0] eng = {eng_tx_active, eng_rx_active, eng_on_state, eng_busoff, eng_err_passive};
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // mirror enables and measure tick spacing
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      gie_ff <= 8'h00;
      cnt_ff <= 8'h00;
      chg_ff <= 1'b1;
      div_ff <= 6'h00;
    end else begin
      if (reg_wr && reg_addr == ADDR_GEN_IRQ_EN) gie_ff <= reg_wdata;
      cnt_ff <= quantum_tick ? 8'h00 : cnt_ff + 8'h01;
      chg_ff <= (quantum_tick ? 1'b0 : chg_ff) | (quantum_divider != div_ff);
      div_ff <= quantum_divider;
    end
  end
  status_read_a: assert property (
    reg_rd && reg_addr == ADDR_GEN_STATUS && $stable(eng) |=> reg_rdata[4:0] == $past(eng))
    else $error("status read differs from engine state");
  can_gate_a: assert property (
    !gie_ff[EN_GLOBAL] && !$past(gie_ff[EN_GLOBAL]) |-> !can_irq)
    else $error("controller request without global enable");
  timer_gate_a: assert property (
    !gie_ff[EN_TIMER_WRAP] && !$past(gie_ff[EN_TIMER_WRAP]) |-> !timer_irq)
    else $error("timer request without its enable");
  timer_cause_a: assert property (
    $rose(timer_irq) |-> $past(ev_timer_wrap, 2) || $past(reg_wr, 2))
    else $error("timer request rose with no cause");
  enable_read_a: assert property (
    reg_rd && reg_addr == ADDR_GEN_IRQ_EN |=> reg_rdata == $past(gie_ff))
    else $error("enable register read back wrong");
  pre_read_a: assert property (
    reg_rd && reg_addr == ADDR_PRESCALER |=> reg_rdata == {1'b0, $past(quantum_divider), 1'b0})
    else $error("prescaler read back wrong");
  div_write_a: assert property (
    reg_wr && reg_addr == ADDR_PRESCALER |=> quantum_divider == $past(reg_wdata[PRE_MSB:PRE_LSB]))
    else $error("divider did not follow write");
  hi_reserved_a: assert property (
    reg_rd && (reg_addr == ADDR_OBJ_EN_HI || reg_addr == ADDR_OBJ_IE_HI
    || reg_addr == ADDR_OBJ_SIT_HI) |=> !reg_rdata[7])
    else $error("reserved top bit read as one");
  tick_period_a: assert property (
    quantum_tick && !chg_ff && quantum_divider == div_ff |-> cnt_ff == {2'b00, quantum_divider})
    else $error("quantum tick spacing wrong");
endmodule
bind csi_regs csi_regs_monitor i_mon (.*);
`default_nettype wire

// file: dv/csi_regs_tb.sv
`default_nettype none
// self-checking bench for the status and interrupt register block
module csi_regs_tb
  import csi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, sys_rst, reg_wr, reg_rd, ev_obj_matched, buffer_cfg_rewritten;
  logic        abort_req, standby_req, quantum_tick, can_irq, timer_irq, ev_timer_handler;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [5:0]  quantum_divider, ev;  // ev bits line up with flag bits
  logic [4:0]  eng;                  // tx, rx, on, bus-off, passive
  logic [14:0] obj_cfg_enable, obj_cfg_disable, obj_done, obj_rx_pend, obj_tx_pend, obj_err_pend;
  int          n_errors, n_checks, k;
  int          cyc = 0;
  typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] e;} csi_row_t;
  // address, written byte, expected read back
  csi_row_t rows [8] = '{'{4'h2, 8'h5a, 8'h5a}, '{4'h5, 8'ha5, 8'ha5}, '{4'h6, 8'hff, 8'h7f},
    '{4'h9, 8'h7e, 8'h7e}, '{4'h0, 8'hff, 8'h00}, '{4'h3, 8'hff, 8'h00},
    '{4'h7, 8'hff, 8'h00}, '{4'hc, 8'hff, 8'h00}};
  csi_regs i_csi_regs (.*, .eng_tx_active(eng[4]), .eng_rx_active(eng[3]), .eng_on_state(eng[2]),
    .eng_busoff(eng[1]), .eng_err_passive(eng[0]), .ev_ack_err(ev[0]), .ev_form_err(ev[1]),
    .ev_crc_err(ev[2]), .ev_stuff_err(ev[3]), .ev_buffer_done(ev[4]), .ev_timer_wrap(ev[5]));
  // compare one byte result
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // one-cycle read, data checked in the following cycle
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // one-cycle engine event
  task automatic pulse(input int i);
    @(posedge mclk);
    ev[i] <= 1'b1;
    @(posedge mclk);
    ev <= 6'h00;
  endtask
  // both request lines two cycles after the cause
  task automatic irq(input logic c, input logic t);
    repeat (2) @(posedge mclk);
    #1 chk({6'h00, can_irq, timer_irq}, {6'h00, c, t});
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      results;
    end
  end
  initial begin
    {sys_rst, reg_wr, reg_rd, ev_obj_matched, buffer_cfg_rewritten, abort_req} = 6'h20;
    {standby_req, ev_timer_handler, reg_addr, reg_wdata, eng, ev} = '0;
    {obj_cfg_enable, obj_cfg_disable, obj_done, obj_rx_pend, obj_tx_pend, obj_err_pend} = '0;
    n_errors = 0;
    n_checks = 0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    for (k = 0; k < 10; k++) rd(k[3:0], 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    @(posedge mclk) eng <= 5'h1d;
    rd(ADDR_GEN_STATUS, 8'h1d);
    @(posedge mclk) eng <= 5'h00;
    #1 chk(reg_rdata, 8'h00);
    wr(ADDR_GEN_IRQ_EN, 8'h82);
    for (k = 0; k < 4; k++) begin
      pulse(k);
      irq(1'b1, 1'b0);
      rd(ADDR_GEN_IRQ_FLAGS, 8'h80 | (8'h01 << k));
      wr(ADDR_GEN_IRQ_FLAGS, 8'h00);
      rd(ADDR_GEN_IRQ_FLAGS, 8'h80 | (8'h01 << k));
      wr(ADDR_GEN_IRQ_FLAGS, 8'h01 << k);
      rd(ADDR_GEN_IRQ_FLAGS, 8'h00);
    end
    wr(ADDR_GEN_IRQ_EN, 8'h02);
    pulse(1);
    irq(1'b0, 1'b0);
    wr(ADDR_GEN_IRQ_FLAGS, 8'h02);
    ev_obj_matched <= 1'b1;
    pulse(2);
    rd(ADDR_GEN_IRQ_FLAGS, 8'h00);
    ev_obj_matched <= 1'b0;
    wr(ADDR_GEN_IRQ_EN, 8'h84);
    pulse(4);
    wr(ADDR_GEN_IRQ_FLAGS, 8'h10);
    rd(ADDR_GEN_IRQ_FLAGS, 8'h90);
    buffer_cfg_rewritten <= 1'b1;
    wr(ADDR_GEN_IRQ_FLAGS, 8'h10);
    rd(ADDR_GEN_IRQ_FLAGS, 8'h00);
    wr(ADDR_GEN_IRQ_EN, 8'h01);
    pulse(5);
    irq(1'b0, 1'b1);
    rd(ADDR_GEN_IRQ_FLAGS, 8'h20);
    @(posedge mclk) ev_timer_handler <= 1'b1;
    @(posedge mclk) ev_timer_handler <= 1'b0;
    rd(ADDR_GEN_IRQ_FLAGS, 8'h00);
    pulse(5);
    wr(ADDR_GEN_IRQ_FLAGS, 8'h20);
    rd(ADDR_GEN_IRQ_FLAGS, 8'h00);
    wr(ADDR_GEN_IRQ_EN, 8'hc0);
    @(posedge mclk) eng <= 5'h01;
    @(posedge mclk) eng <= 5'h03;
    irq(1'b1, 1'b0);
    rd(ADDR_GEN_IRQ_FLAGS, 8'hc0);
    rd(ADDR_GEN_STATUS, 8'h03);
    wr(ADDR_GEN_IRQ_FLAGS, 8'h40);
    rd(ADDR_GEN_IRQ_FLAGS, 8'h00);
    @(posedge mclk) eng <= 5'h00;
    @(posedge mclk) eng <= 5'h02;
    rd(ADDR_GEN_IRQ_FLAGS, 8'h00);
    @(posedge mclk) eng <= 5'h00;
    wr(ADDR_OBJ_IE_LO, 8'h01);
    wr(ADDR_OBJ_IE_HI, 8'h40);
    wr(ADDR_GEN_IRQ_EN, 8'ha0);
    @(posedge mclk) obj_cfg_enable <= 15'h4001;
    @(posedge mclk) obj_cfg_enable <= 15'h0000;
    rd(ADDR_OBJ_EN_LO, 8'h01);
    rd(ADDR_OBJ_EN_HI, 8'h40);
    @(posedge mclk) obj_rx_pend <= 15'h4003;
    irq(1'b1, 1'b0);
    rd(ADDR_OBJ_SIT_LO, 8'h01);
    rd(ADDR_OBJ_SIT_HI, 8'h40);
    @(posedge mclk) obj_rx_pend <= 15'h0000;
    @(posedge mclk) obj_done <= 15'h0001;
    @(posedge mclk) obj_done <= 15'h0000;
    rd(ADDR_OBJ_EN_LO, 8'h00);
    @(posedge mclk) abort_req <= 1'b1;
    @(posedge mclk) abort_req <= 1'b0;
    rd(ADDR_OBJ_EN_HI, 8'h00);
    // disable and standby free objects
    @(posedge mclk) obj_cfg_enable <= 15'h0006;
    @(posedge mclk) obj_cfg_enable <= 15'h0000;
    obj_cfg_disable <= 15'h0002;
    @(posedge mclk) obj_cfg_disable <= 15'h0000;
    rd(ADDR_OBJ_EN_LO, 8'h04);
    @(posedge mclk) standby_req <= 1'b1;
    @(posedge mclk) standby_req <= 1'b0;
    rd(ADDR_OBJ_EN_LO, 8'h00);
    // transmit and error pending need their class enables
    @(posedge mclk) obj_tx_pend <= 15'h0001;
    obj_err_pend <= 15'h4000;
    rd(ADDR_OBJ_SIT_LO, 8'h00);
    wr(ADDR_GEN_IRQ_EN, 8'h98);
    rd(ADDR_OBJ_SIT_LO, 8'h01);
    rd(ADDR_OBJ_SIT_HI, 8'h40);
    irq(1'b1, 1'b0);
    @(posedge mclk) obj_tx_pend <= 15'h0000;
    obj_err_pend <= 15'h0000;
    wr(ADDR_PRESCALER, 8'h06);
    repeat (4) @(posedge mclk);
    k = 0;
    repeat (20) begin
      @(posedge mclk);
      #1 k += quantum_tick;
    end
    chk(k[7:0], 8'h05);
    @(posedge mclk) sys_rst <= 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(ADDR_PRESCALER, 8'h00);
    rd(ADDR_OBJ_IE_LO, 8'h00);
    results;
  end
endmodule
`default_nettype wire
